// ---- logic/fvac_pkg.sv ----
/*
  Package for the field, vertical sync, gain and clamp control bank.
  It holds the register offsets, field positions, reset values, timing
  counts and the packed carriers shared by the design and its bench.
  It assumes nothing of its surroundings.
*/
`default_nettype none
package fvac_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] FVAC_FIELD_CTRL_OFS = 8'h0c;
  localparam logic [7:0] FVAC_SYNC_TIP_OFS   = 8'h0d;
  localparam logic [7:0] FVAC_CLK_PHASE_OFS  = 8'h0e;

  // Field positions in the field and vsync reporting register.
  localparam int FVAC_FREEZE_BIT  = 6;
  localparam int FVAC_DLY_FID_BIT = 2;
  localparam int FVAC_DLY_VS_BIT  = 1;
  localparam int FVAC_AGC_BIT     = 0;
  // Field position in the output clock phase register.
  localparam int FVAC_INVERT_BIT  = 7;

  // Reset values.
  localparam logic       FVAC_FREEZE_RST  = 1'b0;
  localparam logic       FVAC_DLY_FID_RST = 1'b0;
  localparam logic       FVAC_DLY_VS_RST  = 1'b0;
  localparam logic       FVAC_INVERT_RST  = 1'b0;
  localparam logic [3:0] FVAC_TIP_RST     = 4'h0;
  localparam logic [2:0] FVAC_FID_RST     = 3'h0;

  // Timing counts: vsync output low time in lines, gain sequence length.
  localparam logic [1:0] FVAC_VS_LINES    = 2'h3;
  localparam logic [1:0] FVAC_AGC_FIELDS  = 2'h2;

  // Register request from the two-wire port decoder.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fvac_reg_req_t;

  // Video timing events from the sync separator, on the pixel clock.
  typedef struct packed {
    logic ntsc;       // Level: NTSC selected, else PAL.
    logic lock;       // Level: stable sync lock.
    logic vs_start;   // Pulse: detected start of a vertical sync group.
    logic vs_predict; // Pulse: predicted start of a vertical sync series.
    logic line_start; // Pulse: start of a line.
    logic hsync;      // Level: inside horizontal sync.
    logic sync_tip;   // Level: inside a sync tip or equalization pulse.
  } fvac_sync_t;

endpackage
`default_nettype wire

// ---- logic/fvac_top.sv ----
/*
  Field, vertical sync, gain retrigger, sync tip clamp and pixel clock
  phase control for a genlocking video digitizer.
  Assumes the two-wire port decoder and the sync separator run on the
  same pixel clock and hand over one-cycle strobes and levels.
*/
// Functional notes
// [RULE1] Freeze low: NTSC frame bit of the field count toggles freely.
// [RULE2] Freeze high in NTSC: frame bit held, count runs odd/even only.
// [RULE3] Delayed field update low: count steps at each vsync group start.
// [RULE4] Delayed field update high: count steps at the following line start.
// [RULE5] Delayed vsync low: vsync output falls at predicted series start.
// [RULE6] Delayed vsync high: vsync falls one line after detected start.
// [RULE7] Host keeps delay low for clean sources, high for jittery ones.
// [RULE8] Writing one to retrigger starts a one-frame gain run; self-clears.
// [RULE9] Gain runs one frame whenever sync lock is acquired or reacquired.
// [RULE10] When locked, clamp sync tips toward the four-bit tip level.
// [RULE11] Host is advised to program the tip level to three.
// [RULE12] Pixel clock output at normal phase, or inverted when bit set.
// [RULE13] Host leaves the analog test bits at zero.
// [RULE14] NTSC: field count shows on low two video bits during hsync.
// [RULE15] Reserved bits read zero; retrigger bit reads zero.
`timescale 1ns/1ns
`default_nettype none
module fvac_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire fvac_pkg::fvac_reg_req_t reg_req_i,
  input  wire fvac_pkg::fvac_sync_t   sync_i,
  input  wire logic [7:0]             video_i,
  output logic [7:0]                  reg_rdata_o,
  output logic                        reg_rvalid_o,
  output logic [7:0]                  video_o,
  output logic [2:0]                  field_id_o,
  output logic                        vsync_o,
  output logic                        agc_active_o,
  output logic                        pixel_clk_o
);

  // Control register state.
  logic       freeze_q, freeze_d;
  logic       dly_fid_q, dly_fid_d;
  logic       dly_vs_q, dly_vs_d;
  logic       invert_q, invert_d;
  logic [3:0] tip_q, tip_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       agc_kick;

  // Register writes and reads. The retrigger bit is not stored: its write
  // is consumed as a one-cycle kick, so it always reads back as zero.
  always_comb begin
    freeze_d  = freeze_q;
    dly_fid_d = dly_fid_q;
    dly_vs_d  = dly_vs_q;
    invert_d  = invert_q;
    tip_d     = tip_q;
    agc_kick  = 1'b0;
    rdata_d   = 8'h00;
    rvalid_d  = reg_req_i.rd;
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        fvac_pkg::FVAC_FIELD_CTRL_OFS: begin
          freeze_d  = reg_req_i.wdata[fvac_pkg::FVAC_FREEZE_BIT];
          dly_fid_d = reg_req_i.wdata[fvac_pkg::FVAC_DLY_FID_BIT];
          dly_vs_d  = reg_req_i.wdata[fvac_pkg::FVAC_DLY_VS_BIT];
          agc_kick  = reg_req_i.wdata[fvac_pkg::FVAC_AGC_BIT]; // RULE8
        end
        fvac_pkg::FVAC_SYNC_TIP_OFS: begin
          tip_d = reg_req_i.wdata[3:0];
        end
        fvac_pkg::FVAC_CLK_PHASE_OFS: begin
          invert_d = reg_req_i.wdata[fvac_pkg::FVAC_INVERT_BIT];
        end
        default: begin
        end
      endcase
    end
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        fvac_pkg::FVAC_FIELD_CTRL_OFS: begin
          rdata_d[fvac_pkg::FVAC_FREEZE_BIT]  = freeze_q; // RULE15
          rdata_d[fvac_pkg::FVAC_DLY_FID_BIT] = dly_fid_q;
          rdata_d[fvac_pkg::FVAC_DLY_VS_BIT]  = dly_vs_q;
        end
        fvac_pkg::FVAC_SYNC_TIP_OFS: begin
          rdata_d[3:0] = tip_q;
        end
        fvac_pkg::FVAC_CLK_PHASE_OFS: begin
          rdata_d[fvac_pkg::FVAC_INVERT_BIT] = invert_q;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freeze_q  <= fvac_pkg::FVAC_FREEZE_RST;
      dly_fid_q <= fvac_pkg::FVAC_DLY_FID_RST;
      dly_vs_q  <= fvac_pkg::FVAC_DLY_VS_RST;
      invert_q  <= fvac_pkg::FVAC_INVERT_RST;
      tip_q     <= fvac_pkg::FVAC_TIP_RST;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
    end else begin
      freeze_q  <= freeze_d;
      dly_fid_q <= dly_fid_d;
      dly_vs_q  <= dly_vs_d;
      invert_q  <= invert_d;
      tip_q     <= tip_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  // Field identifier. In NTSC only two bits count; the frame bit may be
  // frozen. The frame bit has no tie to burst phase, it just follows the
  // field count.
  logic [2:0] fid_q, fid_d, fid_inc;
  logic       fid_pend_q, fid_pend_d;
  logic       fid_step;

  always_comb begin
    if (sync_i.ntsc) begin
      fid_inc[2] = 1'b0;
      fid_inc[1] = freeze_q ? fid_q[1] : fid_q[1] ^ fid_q[0]; // RULE1 RULE2
      fid_inc[0] = ~fid_q[0];
    end else begin
      fid_inc = fid_q + 3'h1;
    end
    fid_pend_d = fid_pend_q;
    fid_step   = 1'b0;
    if (!dly_fid_q) begin
      fid_step   = sync_i.vs_start; // RULE3
      fid_pend_d = 1'b0;
    end else begin
      if (fid_pend_q && sync_i.line_start) begin
        fid_step   = 1'b1; // RULE4
        fid_pend_d = 1'b0;
      end
      if (sync_i.vs_start) begin
        fid_pend_d = 1'b1; // RULE4
      end
    end
    fid_d = fid_step ? fid_inc : fid_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fid_q      <= fvac_pkg::FVAC_FID_RST;
      fid_pend_q <= 1'b0;
    end else begin
      fid_q      <= fid_d;
      fid_pend_q <= fid_pend_d;
    end
  end

  // Vertical sync output: idles high, falls on the chosen trigger and
  // rises again after a fixed number of lines.
  logic       vs_q, vs_d;
  logic       vs_pend_q, vs_pend_d;
  logic [1:0] vs_lines_q, vs_lines_d;
  logic       vs_fall;

  always_comb begin
    vs_pend_d  = vs_pend_q;
    vs_fall    = 1'b0;
    if (!dly_vs_q) begin
      vs_fall   = sync_i.vs_predict; // RULE5
      vs_pend_d = 1'b0;
    end else begin
      if (vs_pend_q && sync_i.line_start) begin
        vs_fall   = 1'b1; // RULE6
        vs_pend_d = 1'b0;
      end
      if (sync_i.vs_start) begin
        vs_pend_d = 1'b1; // RULE6
      end
    end
    vs_d       = vs_q;
    vs_lines_d = vs_lines_q;
    if (vs_fall) begin
      vs_d       = 1'b0;
      vs_lines_d = 2'h0;
    end else if (!vs_q && sync_i.line_start) begin
      vs_lines_d = vs_lines_q + 2'h1;
      if (vs_lines_q == fvac_pkg::FVAC_VS_LINES - 2'h1) begin
        vs_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vs_q       <= 1'b1;
      vs_pend_q  <= 1'b0;
      vs_lines_q <= 2'h0;
    end else begin
      vs_q       <= vs_d;
      vs_pend_q  <= vs_pend_d;
      vs_lines_q <= vs_lines_d;
    end
  end

  // Gain sequence: one frame, counted as two vsync group starts. A new
  // start while running restarts the frame count.
  logic       agc_q, agc_d;
  logic [1:0] agc_fields_q, agc_fields_d;
  logic       lock_prev_q;
  logic       agc_start;

  always_comb begin
    agc_start    = agc_kick || (sync_i.lock && !lock_prev_q); // RULE8 RULE9
    agc_d        = agc_q;
    agc_fields_d = agc_fields_q;
    if (agc_start) begin
      agc_d        = 1'b1;
      agc_fields_d = 2'h0;
    end else if (agc_q && sync_i.vs_start) begin
      agc_fields_d = agc_fields_q + 2'h1;
      if (agc_fields_q == fvac_pkg::FVAC_AGC_FIELDS - 2'h1) begin
        agc_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agc_q        <= 1'b0;
      agc_fields_q <= 2'h0;
      lock_prev_q  <= 1'b0;
    end else begin
      agc_q        <= agc_d;
      agc_fields_q <= agc_fields_d;
      lock_prev_q  <= sync_i.lock;
    end
  end

  // Digital clamp: a one-step tracking loop moves the offset so that sync
  // tip output settles on the tip level. It is slow but never overshoots
  // by more than one code per sample.
  logic signed [8:0] ofs_q, ofs_d;
  logic signed [9:0] sum;
  logic        [7:0] clamped;
  logic        [7:0] vid_d;

  always_comb begin
    sum = $signed({2'b00, video_i}) + {ofs_q[8], ofs_q};
    if (sum < 10'sd0) begin
      clamped = 8'h00;
    end else if (sum > 10'sd255) begin
      clamped = 8'hff;
    end else begin
      clamped = sum[7:0];
    end
    ofs_d = ofs_q;
    if (sync_i.lock && sync_i.sync_tip) begin
      if (clamped > {4'h0, tip_q} && ofs_q != -9'sd256) begin
        ofs_d = ofs_q - 9'sd1; // RULE10
      end else if (clamped < {4'h0, tip_q} && ofs_q != 9'sd255) begin
        ofs_d = ofs_q + 9'sd1; // RULE10
      end
    end
    vid_d = clamped;
    if (sync_i.hsync) begin
      if (sync_i.ntsc) begin
        vid_d[1:0] = fid_q[1:0]; // RULE14
      end else begin
        vid_d[2:0] = fid_q;
      end
    end
  end

  // Half-rate pixel clock: toggles each cycle, inverted on request.
  logic double_rate_pixel_clock_q, double_rate_pixel_clock_d;
  logic phase_q;

  always_comb begin
    double_rate_pixel_clock_d = phase_q ^ invert_q; // RULE12
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ofs_q   <= 9'sd0;
      video_o <= 8'h00;
      phase_q <= 1'b0;
      double_rate_pixel_clock_q  <= 1'b0;
    end else begin
      ofs_q   <= ofs_d;
      video_o <= vid_d;
      phase_q <= ~phase_q;
      double_rate_pixel_clock_q  <= double_rate_pixel_clock_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign field_id_o   = fid_q;
  assign vsync_o      = vs_q;
  assign agc_active_o = agc_q;
  assign pixel_clk_o  = double_rate_pixel_clock_q;

  // Checks on the behaviour above.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence fid_dly_arm_s;
    dly_fid_q && sync_i.vs_start && !fid_pend_q;
  endsequence
  sequence fid_dly_fire_s;
    fid_pend_q && sync_i.line_start && !sync_i.vs_start;
  endsequence

  frame_bit_free_a: assert property ( // RULE1
    sync_i.ntsc && !freeze_q && fid_step && fid_q[1:0] == 2'h3
    |=> fid_q[1:0] == 2'h0)
    else $error("NTSC frame bit did not wrap with freeze low.");

  frame_bit_hold_a: assert property ( // RULE2
    sync_i.ntsc && freeze_q && $past(sync_i.ntsc) && $past(freeze_q)
    |-> fid_q[1] == $past(fid_q[1]))
    else $error("NTSC frame bit moved while frozen.");

  field_step_now_a: assert property ( // RULE3
    !dly_fid_q && sync_i.vs_start && !sync_i.ntsc
    |=> fid_q == $past(fid_q) + 3'h1)
    else $error("Field count missed a vsync group start.");

  field_step_late_a: assert property ( // RULE4
    fid_dly_arm_s ##1 (dly_fid_q && !sync_i.line_start)
    |-> fid_pend_q && fid_q == $past(fid_q))
    else $error("Delayed field update stepped early.");

  field_late_fire_a: assert property ( // RULE4
    dly_fid_q ##0 fid_dly_fire_s |=> !fid_pend_q && fid_q != $past(fid_q))
    else $error("Delayed field update did not step at line start.");

  vsync_predict_a: assert property ( // RULE5
    !dly_vs_q && sync_i.vs_predict |=> !vsync_o)
    else $error("Vsync output did not fall at predicted start.");

  vsync_delay_a: assert property ( // RULE6
    dly_vs_q && vs_pend_q && sync_i.line_start |=> !vsync_o [*1] ##0
    vs_lines_q == 2'h0)
    else $error("Delayed vsync did not fall at the following line.");

  gain_retrig_a: assert property ( // RULE8
    reg_req_i.wr && reg_req_i.addr == fvac_pkg::FVAC_FIELD_CTRL_OFS
    && reg_req_i.wdata[0] |=> agc_active_o && agc_fields_q == 2'h0)
    else $error("Gain retrigger did not start a sequence.");

  gain_on_lock_a: assert property ( // RULE9
    $rose(sync_i.lock) |=> agc_active_o)
    else $error("Gain sequence not started on lock.");

  gain_one_frame_a: assert property ( // RULE8
    agc_q && !agc_start && sync_i.vs_start && agc_fields_q == 2'h1
    |=> !agc_active_o)
    else $error("Gain sequence did not end after one frame.");

  clamp_track_a: assert property ( // RULE10
    sync_i.lock && sync_i.sync_tip && clamped > {4'h0, tip_q}
    && ofs_q != -9'sd256 |=> ofs_q == $past(ofs_q) - 9'sd1)
    else $error("Clamp did not move toward sync tip level.");

  pix_clk_phase_a: assert property ( // RULE12
    ##2 $past(invert_q) == $past(invert_q, 2)
    |-> pixel_clk_o != $past(pixel_clk_o)
    ##0 pixel_clk_o == (!phase_q ^ $past(invert_q)))
    else $error("Pixel clock phase or toggle wrong.");

  field_on_video_a: assert property ( // RULE14
    sync_i.ntsc && sync_i.hsync |=> video_o[1:0] == $past(fid_q[1:0]))
    else $error("Field count missing from video during hsync.");

  retrig_reads_zero_a: assert property ( // RULE15
    reg_req_i.rd && reg_req_i.addr == fvac_pkg::FVAC_FIELD_CTRL_OFS
    |=> reg_rvalid_o && reg_rdata_o[7] == 1'b0 && reg_rdata_o[5:3] == 3'h0
    && reg_rdata_o[0] == 1'b0)
    else $error("Reserved or retrigger bits read nonzero.");

endmodule
`default_nettype wire

// ---- tb/fvac_host.sv ----
/*
  Host model on the decoded two-wire control port: one byte per access.
  Assumes the strobes are sampled on the rising edge of clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module fvac_host (
  input  wire logic                    clk_i,
  output var fvac_pkg::fvac_reg_req_t req_o
);
  // Idle port at time zero so no strobe is seen as unknown.
  initial begin
    req_o = '0;
  end

  // One access; the strobe stands for one edge, then drops.
  // The analog test bits are never written, so they stay zero.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge clk_i);
    req_o.wr    <= w;
    req_o.rd    <= ~w;
    req_o.addr  <= a;
    req_o.wdata <= d;
    @(posedge clk_i);
    req_o.wr <= 1'b0;
    req_o.rd <= 1'b0;
  endtask

  // Tip three suits most sources; delayed vsync suits jittery ones.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    access(1'b0, a, 8'h00);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the field, vsync, gain and clamp bank.
  Assumes the host model drives the register port and this module
  drives the sync events and samples as the sync separator would.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int VS = 4;
  localparam int VP = 3;
  localparam int LS = 2;
  logic                   clk_i = 1'b0;
  logic                   rst_i;
  logic [6:0]             sy;
  logic [7:0]             video;
  fvac_pkg::fvac_reg_req_t req;
  logic [7:0]             reg_rdata_o;
  logic                   reg_rvalid_o;
  logic [7:0]             video_o;
  logic [2:0]             field_id_o;
  logic                   vsync_o;
  logic                   agc_active_o;
  logic                   pixel_clk_o;
  logic [7:0]             q[$];
  logic [7:0]             tip;
  logic                   p0;
  logic                   ok;
  int                     n_mismatch;
  int                     compares;
  int                     cyc;
  int                     seed;

  // Free-running 25 MHz clock.
  always #20 clk_i = ~clk_i;

  fvac_host host (.clk_i(clk_i), .req_o(req));

  fvac_top DUT (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .reg_req_i   (req),
    .sync_i      (fvac_pkg::fvac_sync_t'(sy)),
    .video_i     (video),
    .reg_rdata_o (reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .video_o     (video_o),
    .field_id_o  (field_id_o),
    .vsync_o     (vsync_o),
    .agc_active_o(agc_active_o),
    .pixel_clk_o (pixel_clk_o)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Note the expected read data, then issue the read.
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host.rd(a);
  endtask

  task automatic pulse(input int b);
    @(posedge clk_i);
    sy[b] <= 1'b1;
    @(posedge clk_i);
    sy[b] <= 1'b0;
  endtask

  // Let one more edge land so either answer latency is settled.
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask

  // Read data is taken against the oldest note when valid shows.
  always @(posedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      check(reg_rdata_o, (q.size() > 0) ? q.pop_front() : 8'hxx);
    end
  end

  // A hang is cut short well past the expected run length.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    seed = 5616;
    rst_i = 1'b1;
    sy = 7'h40;
    video = 8'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h0c, 8'h00);
    rdc(8'h0d, 8'h00);
    rdc(8'h0e, 8'h00);
    host.wr(8'h0f, 8'hff);
    rdc(8'h0f, 8'h00);
    // Four NTSC fields with the id shown on the video bus in hsync.
    @(posedge clk_i) sy[1] <= 1'b1;
    for (int i = 1; i <= 4; i++) begin
      pulse(VS);
      step();
      check({5'h0, field_id_o}, 8'(i % 4));
      check({6'h0, video_o[1:0]}, 8'(i % 4));
    end
    pulse(VP);
    step();
    check({7'h0, vsync_o}, 8'h00);
    repeat (3) pulse(LS);
    step();
    check({7'h0, vsync_o}, 8'h01);
    // Frozen frame bit, delayed field update and delayed vsync.
    host.wr(8'h0c, 8'hfe);
    rdc(8'h0c, 8'h46);
    pulse(VS);
    step();
    check({5'h0, field_id_o}, 8'h00);
    check({7'h0, vsync_o}, 8'h01);
    pulse(LS);
    step();
    check({5'h0, field_id_o}, 8'h01);
    check({7'h0, vsync_o}, 8'h00);
    pulse(VS);
    pulse(LS);
    step();
    check({5'h0, field_id_o}, 8'h00);
    repeat (4) pulse(LS);
    // Retriggered gain run lasts one frame and the bit self-clears.
    host.wr(8'h0c, 8'h47);
    step();
    check({7'h0, agc_active_o}, 8'h01);
    rdc(8'h0c, 8'h46);
    pulse(VS);
    pulse(VS);
    step();
    check({7'h0, agc_active_o}, 8'h00);
    // Lock acquired, lost and reacquired.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i) sy[5] <= 1'b1;
      step();
      step();
      check({7'h0, agc_active_o}, 8'h01);
      pulse(VS);
      pulse(VS);
      @(posedge clk_i) sy[5] <= i[0];
    end
    // Clamp toward a random tip level while locked in sync tips.
    tip = 8'($random(seed));
    host.wr(8'h0d, tip);
    rdc(8'h0d, {4'h0, tip[3:0]});
    @(posedge clk_i) begin
      sy[1] <= 1'b0;
      sy[0] <= 1'b1;
      video <= 8'h10 | (8'($random(seed)) & 8'h0f);
    end
    repeat (300) @(posedge clk_i);
    #1;
    ok = ({1'b0, video_o} + 9'h1 >= {5'h0, tip[3:0]}) &&
         (video_o <= {4'h0, tip[3:0]} + 8'h1);
    check({7'h0, ok}, 8'h01);
    // Pixel clock phase flips against an even count of edges.
    @(posedge clk_i) sy[0] <= 1'b0;
    #1;
    p0 = pixel_clk_o;
    host.wr(8'h0e, 8'hff);
    repeat (2) @(posedge clk_i);
    #1;
    check({7'h0, pixel_clk_o}, {7'h0, ~p0});
    rdc(8'h0e, 8'h80);
    // PAL field count steps at once with the delay bit cleared.
    host.wr(8'h0c, 8'h00);
    @(posedge clk_i) sy[6] <= 1'b0;
    pulse(VS);
    step();
    check({5'h0, field_id_o}, 8'h01);
    repeat (5) @(posedge clk_i);
    check({7'h0, q.size() == 0}, 8'h01);
    give_verdict();
  end
endmodule
`default_nettype wire
